/* File: design/amd_pkg.sv */
// Shared constants and types for the address modifier and byte lane decoder
package amd_pkg;
  // Defined modifier codes, line 5 is the most significant bit, high level reads as 1
  localparam logic [5:0] AM_STD_SUP_BLT = 6'h3F;
  localparam logic [5:0] AM_STD_SUP_PRG = 6'h3E;
  localparam logic [5:0] AM_STD_SUP_DAT = 6'h3D;
  localparam logic [5:0] AM_STD_NP_BLT = 6'h3B;
  localparam logic [5:0] AM_STD_NP_PRG = 6'h3A;
  localparam logic [5:0] AM_STD_NP_DAT = 6'h39;
  localparam logic [5:0] AM_EXT_SUP_BLT = 6'h0F;
  localparam logic [5:0] AM_EXT_SUP_PRG = 6'h0E;
  localparam logic [5:0] AM_EXT_SUP_DAT = 6'h0D;
  localparam logic [5:0] AM_EXT_NP_BLT = 6'h0B;
  localparam logic [5:0] AM_EXT_NP_PRG = 6'h0A;
  localparam logic [5:0] AM_EXT_NP_DAT = 6'h09;
  localparam logic [5:0] AM_SHORT_SUP = 6'h2D;
  localparam logic [5:0] AM_SHORT_NP = 6'h29;
  // Codes 10..1F share this upper pair
  localparam logic [1:0] AM_USER_HI = 2'h1;
  localparam logic [1:0] AM_KIND_BLT = 2'h3;
  localparam logic [1:0] AM_KIND_PRG = 2'h2;
  // Highest address line that selects a four-byte group per class
  localparam logic [4:0] TOP_SHORT = 5'h0F;
  localparam logic [4:0] TOP_STD = 5'h17;
  localparam logic [4:0] TOP_EXT = 5'h1F;
  localparam logic [4:0] TOP_NONE = 5'h00;
  // Byte lane masks, bit i is BYTE(i)
  localparam logic [3:0] MASK_LO_PAIR = 4'h3;
  localparam logic [3:0] MASK_HI_PAIR = 4'hC;
  localparam logic [3:0] MASK_QUAD = 4'hF;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [1:0] LANE_RST = 2'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [29:0] ADDR_RST = 30'h0000_0000;

  typedef enum logic [2:0] {
    AMD_CLS_RSVD = 3'h0,
    AMD_CLS_SHORT = 3'h1,
    AMD_CLS_STD = 3'h2,
    AMD_CLS_EXT = 3'h3,
    AMD_CLS_USER = 3'h4
  } amd_class_t;

  typedef enum logic [1:0] {
    AMD_IDLE = 2'b00,
    AMD_ADDR = 2'b01,
    AMD_XFER = 2'b11,
    AMD_GAP = 2'b10
  } amd_state_t;

  typedef enum logic [1:0] {
    AMD_BLT_NONE = 2'h0,
    AMD_BLT_SGL = 2'h1,
    AMD_BLT_DBL = 2'h2
  } amd_blt_t;
endpackage

/* File: design/amd_am_classify.sv */
// Combinational classifier of the six-bit address modifier
`timescale 1ns/100ps
module amd_am_classify
  import amd_pkg::*;
(
  input wire logic [5:0] am,
  input wire logic [15:0] user_en,
  input wire logic [15:0] user_ext,
  output amd_pkg::amd_class_t cls,
  output logic [4:0] top,
  output logic legal,
  output logic is_super,
  output logic block,
  output logic is_program
);
  always_comb
  begin
    // Every one of the 64 codes lands in exactly one class
    cls = AMD_CLS_RSVD;
    case (am)
      AM_STD_SUP_BLT, AM_STD_SUP_PRG, AM_STD_SUP_DAT,
      AM_STD_NP_BLT, AM_STD_NP_PRG, AM_STD_NP_DAT:
        cls = AMD_CLS_STD;
      AM_EXT_SUP_BLT, AM_EXT_SUP_PRG, AM_EXT_SUP_DAT,
      AM_EXT_NP_BLT, AM_EXT_NP_PRG, AM_EXT_NP_DAT:
        cls = AMD_CLS_EXT;
      AM_SHORT_SUP, AM_SHORT_NP:
        cls = AMD_CLS_SHORT;
      default:
        cls = (am[5:4] == AM_USER_HI) ? AMD_CLS_USER : AMD_CLS_RSVD;
    endcase
    case (cls)
      AMD_CLS_SHORT: top = TOP_SHORT;
      AMD_CLS_STD: top = TOP_STD;
      AMD_CLS_EXT: top = TOP_EXT;
      AMD_CLS_USER: top = user_ext[am[3:0]] ? TOP_EXT : TOP_STD;
      default: top = TOP_NONE;
    endcase
    // User codes answer only where the board enables them
    legal = (cls != AMD_CLS_RSVD) && ((cls != AMD_CLS_USER) || user_en[am[3:0]]);
    // Attributes only for defined codes, so user codes carry no borrowed meaning
    is_super = am[2] && (cls != AMD_CLS_RSVD) && (cls != AMD_CLS_USER);
    block = ((cls == AMD_CLS_STD) || (cls == AMD_CLS_EXT)) && (am[1:0] == AM_KIND_BLT);
    is_program = ((cls == AMD_CLS_STD) || (cls == AMD_CLS_EXT)) &&
                 (am[1:0] == AM_KIND_PRG);
  end
endmodule

/* File: design/amd_decoder.sv */
// Slave-side address modifier, address width and block transfer byte lane tracker
`timescale 1ns/100ps
module amd_decoder
  import amd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic lword_n,
  input wire logic write_n,
  input wire logic [31:1] addr,
  input wire logic [5:0] am,
  input wire logic [15:0] user_en,
  input wire logic [15:0] user_ext,
  output logic cyc_active,
  output amd_pkg::amd_class_t am_class,
  output logic am_super,
  output logic am_block,
  output logic am_program,
  output logic slave_sel,
  output logic [31:2] addr_sel,
  output amd_pkg::amd_blt_t blt_mode,
  output logic xfer_start,
  output logic [1:0] lane_byte,
  output logic [3:0] lane_mask,
  output logic wr_data_valid,
  output logic rd_release,
  output logic [7:0] xfer_count,
  output logic seq_err
);
  amd_state_t state_q, state_d;
  amd_class_t cls_c, cls_q, cls_d;
  amd_blt_t blt_q, blt_d;
  logic [4:0] top_c;
  logic legal_c, super_c, block_c, program_c;
  logic sel_q, sel_d, super_q, super_d, block_q, block_d, program_q, program_d;
  logic [29:0] addr_q, addr_d, addr_mask;
  logic as_prev_q, ds0_prev_q, ds1_prev_q;
  logic first_q, first_d, start_q, start_d, wr_q, wr_d, rd_q, rd_d, err_q, err_d;
  logic [1:0] lane_q, lane_d, last_ds_q, last_ds_d;
  logic [3:0] mask_q, mask_d;
  logic [7:0] count_q, count_d;
  logic [1:0] ds_act;
  logic as_fall, ds_fall, ds_rise, begin_xfer;

  amd_am_classify u_classify (
    .am(am),
    .user_en(user_en),
    .user_ext(user_ext),
    .cls(cls_c),
    .top(top_c),
    .legal(legal_c),
    .is_super(super_c),
    .block(block_c),
    .is_program(program_c)
  );

  // Keep only the address lines that the modifier class says are in use
  for (genvar i = 0; i < 30; i++)
  begin : g_mask
    assign addr_mask[i] = ((i + 2) <= int'(top_c)) && (top_c != TOP_NONE);
  end

  assign ds_act = {~ds1_n, ~ds0_n};
  assign as_fall = as_prev_q && !as_n;
  assign ds_fall = (ds0_prev_q && !ds0_n) || (ds1_prev_q && !ds1_n);
  assign ds_rise = (!ds0_prev_q && ds0_n) || (!ds1_prev_q && ds1_n);
  // A strobe may be seen before AS on a loaded backplane, so the first one is a level
  assign begin_xfer = ((state_q == AMD_ADDR) && (ds_act != 2'h0)) ||
                      ((state_q == AMD_GAP) && ds_fall);

  always_comb
  begin
    state_d = state_q;
    cls_d = cls_q;
    sel_d = sel_q;
    super_d = super_q;
    block_d = block_q;
    program_d = program_q;
    addr_d = addr_q;
    first_d = first_q;
    blt_d = blt_q;
    lane_d = lane_q;
    last_ds_d = last_ds_q;
    mask_d = mask_q;
    count_d = count_q;
    err_d = err_q;
    start_d = 1'b0;
    wr_d = 1'b0;
    rd_d = 1'b0;
    case (state_q)
      AMD_IDLE:
        if (as_fall)
        begin
          // Address and modifier are frozen together for the whole cycle
          state_d = AMD_ADDR;
          addr_d = addr[31:2] & addr_mask;
          cls_d = cls_c;
          sel_d = legal_c;
          super_d = super_c;
          block_d = block_c;
          program_d = program_c;
          first_d = 1'b1;
          blt_d = AMD_BLT_NONE;
          count_d = COUNT_RST;
          err_d = 1'b0;
          mask_d = MASK_NONE;
        end
      AMD_ADDR, AMD_GAP:
        if (as_n)
        begin
          // Address-only cycle ends here with no lane decode at all
          state_d = AMD_IDLE;
        end
        else if (begin_xfer)
        begin
          state_d = AMD_XFER;
          start_d = 1'b1;
          wr_d = !write_n;
          count_d = count_q + 8'h01;
          last_ds_d = ds_act;
          first_d = 1'b0;
          if (first_q)
          begin
            // A01 is trusted only here, before any acknowledge
            if (block_q && (ds_act == 2'h3))
            begin
              blt_d = AMD_BLT_DBL;
              lane_d = {addr[1], 1'b0};
            end
            else
            begin
              blt_d = block_q ? AMD_BLT_SGL : AMD_BLT_NONE;
              lane_d = {addr[1], ds_act == 2'h1};
            end
            if (ds_act == 2'h3)
              mask_d = (!lword_n && !block_q) ? MASK_QUAD :
                       (addr[1] ? MASK_HI_PAIR : MASK_LO_PAIR);
            else
              mask_d = 4'h1 << {addr[1], ds_act == 2'h1};
          end
          else
          begin
            case (blt_q)
              AMD_BLT_SGL:
              begin
                lane_d = lane_q + 2'h1;
                mask_d = 4'h1 << (lane_q + 2'h1);
                err_d = err_q || (ds_act == 2'h3) || (ds_act == last_ds_q);
              end
              AMD_BLT_DBL:
              begin
                lane_d = lane_q ^ 2'h2;
                mask_d = lane_q[1] ? MASK_LO_PAIR : MASK_HI_PAIR;
                err_d = err_q || (ds_act != 2'h3);
              end
              default:
                lane_d = lane_q;
            endcase
          end
        end
      AMD_XFER:
        if (as_n)
          state_d = AMD_IDLE;
        else if (ds_rise)
        begin
          // Only the first rising strobe of a transfer releases read data
          state_d = AMD_GAP;
          rd_d = write_n;
        end
      default:
        state_d = AMD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= AMD_IDLE;
      cls_q <= AMD_CLS_RSVD;
      sel_q <= 1'b0;
      super_q <= 1'b0;
      block_q <= 1'b0;
      program_q <= 1'b0;
      addr_q <= ADDR_RST;
      as_prev_q <= 1'b1;
      ds0_prev_q <= 1'b1;
      ds1_prev_q <= 1'b1;
      first_q <= 1'b0;
      blt_q <= AMD_BLT_NONE;
      lane_q <= LANE_RST;
      last_ds_q <= 2'h0;
      mask_q <= MASK_NONE;
      count_q <= COUNT_RST;
      err_q <= 1'b0;
      start_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cls_q <= cls_d;
      sel_q <= sel_d;
      super_q <= super_d;
      block_q <= block_d;
      program_q <= program_d;
      addr_q <= addr_d;
      as_prev_q <= as_n;
      ds0_prev_q <= ds0_n;
      ds1_prev_q <= ds1_n;
      first_q <= first_d;
      blt_q <= blt_d;
      lane_q <= lane_d;
      last_ds_q <= last_ds_d;
      mask_q <= mask_d;
      count_q <= count_d;
      err_q <= err_d;
      start_q <= start_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  assign cyc_active = (state_q != AMD_IDLE);
  assign am_class = cls_q;
  assign am_super = super_q;
  assign am_block = block_q;
  assign am_program = program_q;
  // Select drops with AS so a stale decode never answers the next cycle
  assign slave_sel = sel_q && cyc_active;
  assign addr_sel = addr_q;
  assign blt_mode = blt_q;
  assign xfer_start = start_q;
  assign lane_byte = lane_q;
  assign lane_mask = mask_q;
  assign wr_data_valid = wr_q;
  assign rd_release = rd_q;
  assign xfer_count = count_q;
  assign seq_err = err_q;

  // Lane held before each new transfer, seen only by the checks below
  logic [1:0] lane_prev_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lane_prev_q <= LANE_RST;
    else if (start_q)
      lane_prev_q <= lane_q;
  end

  sequence s_later_start;
    start_q && (count_q > 8'h01);
  endsequence

  rsvd_no_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_active && (cls_q == AMD_CLS_RSVD) |-> !slave_sel)
    else $error("reserved modifier selected the slave");
  short_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cls_q == AMD_CLS_SHORT) |-> (addr_q[29:14] == 16'h0000))
    else $error("short class kept lines above A15");
  std_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == AMD_IDLE) && as_fall && (cls_c == AMD_CLS_STD) |=>
    (addr_q == {8'h00, $past(addr[23:2])}))
    else $error("standard class address capture wrong");
  ext_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == AMD_IDLE) && as_fall && (cls_c == AMD_CLS_EXT) |=> (addr_q == $past(addr[31:2])))
    else $error("extended class address capture wrong");
  class_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_active && $past(cyc_active) |-> $stable(cls_q) && $stable(sel_q))
    else $error("modifier class changed inside a cycle");
  sgl_walk_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_later_start and (blt_q == AMD_BLT_SGL) |-> (lane_q == lane_prev_q + 2'h1))
    else $error("single-byte block lane did not advance by one");
  dbl_walk_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_later_start and (blt_q == AMD_BLT_DBL) |-> (lane_q == (lane_prev_q ^ 2'h2)))
    else $error("double-byte block pair did not alternate");
  addr_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == AMD_ADDR) && ds0_n && ds1_n |=> !start_q && !wr_q)
    else $error("transfer seen with both strobes high");
  wr_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
    begin_xfer && !as_n |=> start_q && (wr_q == $past(!write_n)) && (state_q == AMD_XFER))
    else $error("write data valid pulse wrong at strobe fall");
endmodule

/* File: tb/amd_bus_master.sv */
// Behavioural bus master driving modifier, address and strobes
`timescale 1ns/100ps
module amd_bus_master
(
  input wire logic clk,
  output logic as_n,
  output logic ds0_n,
  output logic ds1_n,
  output logic lword_n,
  output logic write_n,
  output logic [31:1] addr,
  output logic [5:0] am
);
  initial
  begin
    as_n = 1'b1;
    ds0_n = 1'b1;
    ds1_n = 1'b1;
    lword_n = 1'b1;
    write_n = 1'b1;
    addr = '0;
    am = 6'h00;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Address and modifier go out with the address strobe fall
  task automatic start(input logic [5:0] code, input logic [31:1] a, input logic wr);
    @(negedge clk);
    am = code;
    addr = a;
    write_n = ~wr;
    as_n = 1'b0;
    idle(2);
  endtask

  // After the first transfer A01 and LWORD are don't-care, so they flip to catch reuse
  task automatic xfer(input logic s1, input logic s0);
    ds1_n = ~s1;
    ds0_n = ~s0;
    idle(2);
    ds1_n = 1'b1;
    ds0_n = 1'b1;
    addr[1] = ~addr[1];
    lword_n = ~lword_n;
    idle(2);
  endtask

  // Long word line for the first transfer of a non-block cycle
  task automatic long_word(input logic lw);
    lword_n = ~lw;
  endtask

  // AS rises to end any cycle, and address and modifier flip to catch reuse after it
  task automatic finish();
    as_n = 1'b1;
    addr = ~addr;
    am = ~am;
    idle(2);
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the modifier and byte lane decoder
`timescale 1ns/100ps
module tb;
  import amd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] user_en = 16'h00FF;
  logic [15:0] user_ext = 16'h0F0F;
  wire logic as_n, ds0_n, ds1_n, lword_n, write_n;
  wire logic [31:1] addr;
  wire logic [5:0] am;
  logic cyc_active, am_super, am_block, am_program, slave_sel, xfer_start;
  logic wr_data_valid, rd_release, seq_err;
  amd_class_t am_class;
  amd_blt_t blt_mode;
  logic [31:2] addr_sel;
  logic [1:0] lane_byte;
  logic [3:0] lane_mask;
  logic [7:0] xfer_count;
  int n_mismatch = 0;
  int check_count = 0;
  int n_wr = 0;
  int n_rd = 0;
  int n_st = 0;

  always #10 clk = ~clk;

  // Pulses are counted at the falling edge, where they have settled
  always @(negedge clk)
  begin
    if (wr_data_valid === 1'b1) n_wr++;
    if (rd_release === 1'b1) n_rd++;
    if (xfer_start === 1'b1) n_st++;
  end

  amd_bus_master amd_bus_master_inst (.clk(clk), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
    .lword_n(lword_n), .write_n(write_n), .addr(addr), .am(am));

  amd_decoder amd_decoder_inst (.clk(clk), .rst_n(rst_n), .as_n(as_n), .ds0_n(ds0_n),
    .ds1_n(ds1_n), .lword_n(lword_n), .write_n(write_n), .addr(addr), .am(am),
    .user_en(user_en), .user_ext(user_ext), .cyc_active(cyc_active), .am_class(am_class),
    .am_super(am_super), .am_block(am_block), .am_program(am_program),
    .slave_sel(slave_sel), .addr_sel(addr_sel), .blt_mode(blt_mode),
    .xfer_start(xfer_start), .lane_byte(lane_byte), .lane_mask(lane_mask),
    .wr_data_valid(wr_data_valid), .rd_release(rd_release), .xfer_count(xfer_count),
    .seq_err(seq_err));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [2:0] cls_of(input logic [5:0] c);
    if (c == 6'h2D || c == 6'h29) return AMD_CLS_SHORT;
    if (c[5:4] == 2'h1) return AMD_CLS_USER;
    if ((c[5:3] == 3'h1 || c[5:3] == 3'h7) && c[1:0] != 2'h0)
      return c[5] ? AMD_CLS_STD : AMD_CLS_EXT;
    return AMD_CLS_RSVD;
  endfunction

  // Every modifier code in an address-only cycle
  task automatic t_classify();
    logic [5:0] c;
    logic [2:0] k;
    logic sel;
    logic [29:0] m;
    for (int i = 0; i < 64; i++)
    begin
      c = i[5:0];
      k = cls_of(c);
      sel = k != AMD_CLS_RSVD && (k != AMD_CLS_USER || user_en[c[3:0]]);
      m = 30'h003F_FFFF;
      if (k == AMD_CLS_SHORT) m = 30'h0000_3FFF;
      if (k == AMD_CLS_EXT || (k == AMD_CLS_USER && user_ext[c[3:0]])) m = 30'h3FFF_FFFF;
      if (k == AMD_CLS_RSVD) m = 30'h0000_0000;
      amd_bus_master_inst.start(c, 31'h7FFF_FFFF, 1'b0);
      check("am_class", am_class, k);
      check("slave_sel", slave_sel, sel);
      check("addr_sel", addr_sel, m);
      check("cyc_active", cyc_active, 1'b1);
      if (k != AMD_CLS_RSVD)
      begin
        check("am_super", am_super, k != AMD_CLS_USER && c[2]);
        check("am_block", am_block, k != AMD_CLS_USER && c[1:0] == 2'h3);
        check("am_program", am_program, k != AMD_CLS_USER && c[1:0] == 2'h2);
      end
      check("xfer_count", xfer_count, 8'h00);
      amd_bus_master_inst.finish();
      check("slave_sel_end", slave_sel, 1'b0);
      check("cyc_end", cyc_active, 1'b0);
    end
    $display("test classify done");
  endtask

  task automatic t_single(input logic [1:0] b);
    logic [1:0] ln;
    int nw0;
    int nr0;
    int ns0;
    ln = b;
    nw0 = n_wr;
    nr0 = n_rd;
    ns0 = n_st;
    amd_bus_master_inst.start(AM_STD_NP_BLT, {30'h0000_1234, b[1]}, b[0]);
    for (int i = 0; i < 5; i++)
    begin
      amd_bus_master_inst.xfer(~ln[0], ln[0]);
      check("lane_byte", lane_byte, ln);
      check("lane_mask", lane_mask, 4'h1 << ln);
      ln = ln + 2'h1;
    end
    check("blt_mode", blt_mode, AMD_BLT_SGL);
    check("xfer_count", xfer_count, 8'h05);
    check("st_pulses", n_st - ns0, 5);
    check("seq_err", seq_err, 1'b0);
    check("wr_pulses", n_wr - nw0, b[0] ? 5 : 0);
    check("rd_pulses", n_rd - nr0, b[0] ? 0 : 5);
    amd_bus_master_inst.finish();
    $display("test single byte block done");
  endtask

  task automatic t_double(input logic a1);
    logic [1:0] ln;
    ln = {a1, 1'b0};
    amd_bus_master_inst.start(AM_EXT_SUP_BLT, {30'h2000_0040, a1}, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      amd_bus_master_inst.xfer(1'b1, 1'b1);
      check("lane_byte", lane_byte, ln);
      check("lane_mask", lane_mask, ln[1] ? 4'hC : 4'h3);
      ln = ln ^ 2'h2;
    end
    check("blt_mode", blt_mode, AMD_BLT_DBL);
    check("xfer_count", xfer_count, 8'h04);
    check("seq_err", seq_err, 1'b0);
    amd_bus_master_inst.finish();
    $display("test double byte block done");
  endtask

  // Same strobe twice in a single-byte block, then a clean cycle clears the flag
  task automatic t_error();
    amd_bus_master_inst.start(AM_STD_SUP_BLT, 31'h0000_0000, 1'b0);
    amd_bus_master_inst.xfer(1'b1, 1'b0);
    amd_bus_master_inst.xfer(1'b1, 1'b0);
    check("seq_err", seq_err, 1'b1);
    amd_bus_master_inst.finish();
    amd_bus_master_inst.start(AM_STD_SUP_BLT, 31'h0000_0000, 1'b0);
    check("seq_err_clr", seq_err, 1'b0);
    amd_bus_master_inst.finish();
    $display("test strobe error done");
  endtask

  // Quad lanes on a non-block first transfer, then a second transfer keeps them
  task automatic t_quad();
    int ns0;
    ns0 = n_st;
    amd_bus_master_inst.start(AM_EXT_NP_DAT, {30'h0000_0100, 1'b0}, 1'b1);
    amd_bus_master_inst.long_word(1'b1);
    amd_bus_master_inst.xfer(1'b1, 1'b1);
    check("quad_mask", lane_mask, 4'hF);
    check("quad_blt", blt_mode, AMD_BLT_NONE);
    amd_bus_master_inst.xfer(1'b1, 1'b1);
    check("rmw_mask", lane_mask, 4'hF);
    check("rmw_lane", lane_byte, 2'h0);
    check("rmw_count", xfer_count, 8'h02);
    check("rmw_starts", n_st - ns0, 2);
    check("rmw_err", seq_err, 1'b0);
    amd_bus_master_inst.finish();
    amd_bus_master_inst.long_word(1'b0);
    $display("test quad lanes done");
  endtask

  initial
  begin
    #1ms;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (5) @(negedge clk);
    check("reset_cls", am_class, AMD_CLS_RSVD);
    check("reset_cyc", cyc_active, 1'b0);
    rst_n = 1'b1;
    t_classify();
    for (int b = 0; b < 4; b++)
      t_single(b[1:0]);
    t_double(1'b0);
    t_double(1'b1);
    t_error();
    t_quad();
    summarize();
  end
endmodule
